// file: design/rsl_pkg.sv
// Package: constants and types of the reset state loader
package rsl_pkg;
   localparam int unsigned RSL_PC_W = 13;
   localparam logic [12:0] RSL_PC_RESET = 13'h0000;
   localparam logic [12:0] RSL_PC_VECTOR = 13'h0004;
   localparam logic [7:0] RSL_OPTION_RESET = 8'hff;
   // STATUS image on cold reset: timeout and powerdown flags set
   localparam logic [7:0] RSL_STATUS_COLD = 8'h18;
   localparam int unsigned RSL_TIMEOUT_BIT = 4;
   localparam int unsigned RSL_POWERDOWN_BIT = 3;
   localparam int unsigned RSL_POR_BIT = 1;
   localparam int unsigned RSL_BROWNOUT_BIT = 0;
   localparam logic [7:0] RSL_IRQCTL_RESET = 8'h00;
   localparam logic [7:0] RSL_IRQCTL_IMPL = 8'hff;
   // Reserved bit 7 of flag reg one, bits 7..5 and 2..0 absent in flag reg two
   localparam logic [7:0] RSL_PFR1_IMPL = 8'h7f;
   localparam logic [7:0] RSL_PFR2_IMPL = 8'h18;
   localparam logic [1:0] RSL_PWR_IMPL = 2'h3;
   localparam int unsigned RSL_IRQ_ENABLE_BIT = 7;

   typedef enum logic [2:0] {
      RSL_NONE = 3'b000,
      RSL_POR = 3'b001,
      RSL_BROWNOUT = 3'b010,
      RSL_PIN = 3'b011,
      RSL_PIN_SLEEP = 3'b100,
      RSL_WDT = 3'b101,
      RSL_WAKE_WDT = 3'b110,
      RSL_WAKE_IRQ = 3'b111
   } rsl_cause_e;

   typedef struct packed {
      logic [12:0] pc;
      logic [7:0] status;
      logic [7:0] option;
      logic [7:0] irqctl;
      logic [7:0] pfr1;
      logic [7:0] pfr2;
      logic [1:0] pwr;
      logic [7:0] gen;
      rsl_cause_e cause;
      logic load;
   } rsl_state_s;
endpackage : rsl_pkg

// file: design/rsl_loader.sv
// Reset state loader: picks register values on reset and wake-up
// Notes on behaviour
// RULE1: Wake-up resumes at PC+1; interrupt wake with global enable loads vector.
// RULE2: Interrupt wake-up sets a flag bit in interrupt control or peripheral flag regs.
// RULE3: Unimplemented bit positions always read back as zero.
// RULE4: Software keeps reserved flag and enable bits written as zero.
// RULE5: Timeout, powerdown and power status bits depend on the reset cause.
// RULE6: Option register loads all ones on resets, unchanged on wake-up.
// RULE7: Defined-state registers load on all resets, untouched on watchdog wake (code still ORs the wake flag inputs into interrupt control and flag regs).
// RULE8: Unscheme registers power up unknown and hold through other resets.
// RULE9: Power-on/brown-out beat pin/watchdog, which beat wake-up.
module rsl_loader
   import rsl_pkg::*;
(
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_NRST,
   // Reset and wake cause pulses, one cycle each, and the sleep level
   input wire logic I_POR,
   input wire logic I_BROWNOUT_RESET_EVENT,
   input wire logic I_MASTER_CLEAR_PIN,
   input wire logic I_WDT_TIMEOUT,
   input wire logic I_IRQ_WAKE,
   input wire logic I_SLEEPING,
   // Current core state
   input wire logic [12:0] I_PC,
   input wire logic [7:0] I_WAKE_FLAGS1,
   input wire logic [7:0] I_WAKE_FLAGS2,
   input wire logic [7:0] I_WAKE_IRQCTL,
   input wire logic [7:0] I_OPTION_WR,
   input wire logic I_OPTION_WE,
   input wire logic [7:0] I_GEN_WR,
   input wire logic I_GEN_WE,
   // Loaded images
   output logic [12:0] O_PC,
   output logic [7:0] O_STATUS,
   output logic [7:0] O_OPTION,
   output logic [7:0] O_IRQ_CONTROL_REG,
   output logic [7:0] O_PERIPH_FLAG_REG_ONE,
   output logic [7:0] O_PERIPH_FLAG_REG_TWO,
   output logic [1:0] O_POWER_STATUS_REG,
   output logic [7:0] O_GEN_REG,
   output logic [2:0] O_CAUSE,
   output logic O_LOAD
);
   rsl_state_s s_q;
   rsl_state_s s_d;
   rsl_cause_e c;
   logic sleep_wake;
   logic irq_enable;

   //----------------------------------------
   // Cause decode and register images
   //----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.load = 1'b0;
      sleep_wake = I_SLEEPING & (I_WDT_TIMEOUT | I_IRQ_WAKE);
      // Enable is taken from the image before this wake; flags arriving now cannot vector
      irq_enable = s_q.irqctl[RSL_IRQ_ENABLE_BIT];
      // Highest class wins when causes coincide
      if (I_POR) begin // see RULE9
         c = RSL_POR;
      end else if (I_BROWNOUT_RESET_EVENT) begin
         c = RSL_BROWNOUT;
      end else if (I_MASTER_CLEAR_PIN) begin
         c = I_SLEEPING ? RSL_PIN_SLEEP : RSL_PIN;
      end else if (I_WDT_TIMEOUT && !I_SLEEPING) begin
         c = RSL_WDT;
      end else if (sleep_wake) begin
         c = I_WDT_TIMEOUT ? RSL_WAKE_WDT : RSL_WAKE_IRQ;
      end else begin
         c = RSL_NONE;
      end
      if (I_OPTION_WE) begin
         s_d.option = I_OPTION_WR;
      end
      if (I_GEN_WE) begin
         s_d.gen = I_GEN_WR;
      end
      case (c)
         RSL_POR, RSL_BROWNOUT, RSL_PIN, RSL_PIN_SLEEP, RSL_WDT: begin
            s_d.pc = RSL_PC_RESET; // see RULE7
            s_d.option = RSL_OPTION_RESET; // see RULE6
            s_d.irqctl = RSL_IRQCTL_RESET; // see RULE7
            s_d.pfr1 = 8'h00;
            s_d.pfr2 = 8'h00;
            // General register is kept except on power-on: only content outside the scheme
            s_d.status[7:5] = 3'h0; // see RULE5
            case (c)
               RSL_POR: begin
                  s_d.status[RSL_TIMEOUT_BIT] = 1'b1;
                  s_d.status[RSL_POWERDOWN_BIT] = 1'b1;
                  s_d.pwr[RSL_POR_BIT] = 1'b0; // see RULE5
               end
               RSL_BROWNOUT: begin
                  s_d.status[RSL_TIMEOUT_BIT] = 1'b1;
                  s_d.status[RSL_POWERDOWN_BIT] = 1'b1;
                  s_d.pwr[RSL_BROWNOUT_BIT] = 1'b0;
               end
               RSL_PIN_SLEEP: begin
                  s_d.status[RSL_TIMEOUT_BIT] = 1'b1;
                  s_d.status[RSL_POWERDOWN_BIT] = 1'b0;
               end
               RSL_WDT: begin
                  s_d.status[RSL_TIMEOUT_BIT] = 1'b0;
                  s_d.status[RSL_POWERDOWN_BIT] = 1'b1;
               end
               default: begin
               end
            endcase
            if (c == RSL_POR) begin
               // Unknown on power-up; held at zero here as the modelled value
               s_d.gen = 8'h00; // see RULE8
               s_d.status[2:0] = 3'h0;
            end
            s_d.load = 1'b1;
         end
         RSL_WAKE_WDT, RSL_WAKE_IRQ: begin
            s_d.pc = I_PC + 13'h0001; // see RULE1
            if (c == RSL_WAKE_IRQ && irq_enable) begin
               s_d.pc = RSL_PC_VECTOR; // see RULE1
            end
            s_d.status[RSL_TIMEOUT_BIT] = (c == RSL_WAKE_IRQ);
            s_d.status[RSL_POWERDOWN_BIT] = 1'b0; // see RULE5
            s_d.irqctl = s_q.irqctl | I_WAKE_IRQCTL; // see RULE2
            s_d.pfr1 = s_q.pfr1 | I_WAKE_FLAGS1;
            s_d.pfr2 = s_q.pfr2 | I_WAKE_FLAGS2;
            // Interrupt wake with no source reported: mark the peripheral summary
            // Only implemented positions count, since masked flags would leave nothing visible
            if (c == RSL_WAKE_IRQ && (I_WAKE_IRQCTL | (I_WAKE_FLAGS1 & RSL_PFR1_IMPL)
                  | (I_WAKE_FLAGS2 & RSL_PFR2_IMPL)) == 8'h00) begin
               s_d.irqctl[0] = 1'b1; // see RULE2
            end
            s_d.load = 1'b1;
         end
         default: begin
         end
      endcase
      // Absent and reserved positions forced to zero every cycle
      s_d.irqctl = s_d.irqctl & RSL_IRQCTL_IMPL; // see RULE3
      s_d.pfr1 = s_d.pfr1 & RSL_PFR1_IMPL; // see RULE3
      s_d.pfr2 = s_d.pfr2 & RSL_PFR2_IMPL; // see RULE3
      // Power status bits have no write path here, so only resets ever move them
      s_d.pwr = s_d.pwr & RSL_PWR_IMPL;
      s_d.cause = c;
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_NRST) begin
         s_q <= '{pc: RSL_PC_RESET, status: RSL_STATUS_COLD, option: RSL_OPTION_RESET,
                  irqctl: RSL_IRQCTL_RESET, pfr1: 8'h00, pfr2: 8'h00, pwr: 2'h0,
                  gen: 8'h00, cause: RSL_NONE, load: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   //----------------------------------------
   // Outputs, all straight from the state register
   //----------------------------------------
   assign O_PC = s_q.pc;
   assign O_STATUS = s_q.status;
   assign O_OPTION = s_q.option;
   assign O_IRQ_CONTROL_REG = s_q.irqctl;
   assign O_PERIPH_FLAG_REG_ONE = s_q.pfr1;
   assign O_PERIPH_FLAG_REG_TWO = s_q.pfr2;
   assign O_POWER_STATUS_REG = s_q.pwr;
   assign O_GEN_REG = s_q.gen;
   assign O_CAUSE = s_q.cause;
   assign O_LOAD = s_q.load;

   //----------------------------------------
   // Checks
   //----------------------------------------
   wake_pc_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE1
      (!I_POR && !I_BROWNOUT_RESET_EVENT && !I_MASTER_CLEAR_PIN && I_SLEEPING && I_WDT_TIMEOUT)
      |=> O_PC == $past(I_PC) + 13'h0001)
      else $error("watchdog wake pc not pc plus one");
   wake_vector_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE1
      (c == RSL_WAKE_IRQ && irq_enable) |=> O_PC == RSL_PC_VECTOR)
      else $error("irq wake did not vector");
   wake_flag_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE2
      (c == RSL_WAKE_IRQ) |=> (O_IRQ_CONTROL_REG | O_PERIPH_FLAG_REG_ONE | O_PERIPH_FLAG_REG_TWO) != 8'h00)
      else $error("wake left no flag");
   unimpl_zero_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE3
      (O_PERIPH_FLAG_REG_ONE & ~RSL_PFR1_IMPL) == 8'h00 && (O_PERIPH_FLAG_REG_TWO & ~RSL_PFR2_IMPL) == 8'h00)
      else $error("unimplemented bit set");
   status_cause_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE5
      (c == RSL_WDT) |=> !O_STATUS[RSL_TIMEOUT_BIT] && O_STATUS[RSL_POWERDOWN_BIT] && O_LOAD)
      else $error("watchdog reset status wrong");
   por_flag_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE5
      I_POR |=> !O_POWER_STATUS_REG[RSL_POR_BIT] && O_STATUS[RSL_TIMEOUT_BIT] && O_STATUS[RSL_POWERDOWN_BIT])
      else $error("power-on status wrong");
   option_keep_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE6
      (sleep_wake && !I_POR && !I_BROWNOUT_RESET_EVENT && !I_MASTER_CLEAR_PIN && !I_OPTION_WE)
      |=> $stable(O_OPTION))
      else $error("option changed on wake");
   option_ones_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE6
      (I_MASTER_CLEAR_PIN || I_BROWNOUT_RESET_EVENT) |=> O_OPTION == RSL_OPTION_RESET && O_PC == RSL_PC_RESET)
      else $error("option not all ones on reset");
   gen_keep_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE8
      (!I_POR && !I_GEN_WE) |=> $stable(O_GEN_REG))
      else $error("general register changed");
   cause_prio_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE9
      (I_POR && I_MASTER_CLEAR_PIN) |=> O_CAUSE == RSL_POR)
      else $error("priority wrong");
   pin_sleep_status_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE5
      (c == RSL_PIN_SLEEP) |=> O_STATUS[RSL_TIMEOUT_BIT] && !O_STATUS[RSL_POWERDOWN_BIT] && O_PC == RSL_PC_RESET)
      else $error("pin reset in sleep status wrong");
   wdt_wake_status_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE5
      (c == RSL_WAKE_WDT) |=> !O_STATUS[RSL_TIMEOUT_BIT] && !O_STATUS[RSL_POWERDOWN_BIT] && O_LOAD)
      else $error("watchdog wake status wrong");
   brownout_flag_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE5
      (I_BROWNOUT_RESET_EVENT && !I_POR) |=> !O_POWER_STATUS_REG[RSL_BROWNOUT_BIT] && O_STATUS[RSL_TIMEOUT_BIT])
      else $error("brown-out status wrong");
   reset_clear_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE7
      (c == RSL_PIN || c == RSL_WDT) |=> O_IRQ_CONTROL_REG == RSL_IRQCTL_RESET && O_PERIPH_FLAG_REG_ONE == 8'h00
         && O_PERIPH_FLAG_REG_TWO == 8'h00)
      else $error("reset left interrupt flags set");
   wake_keep_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE7
      (c == RSL_WAKE_WDT) |=> (O_IRQ_CONTROL_REG & $past(O_IRQ_CONTROL_REG)) == $past(O_IRQ_CONTROL_REG))
      else $error("watchdog wake cleared a flag");
   awake_irq_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST) // see RULE1
      (I_IRQ_WAKE && !I_SLEEPING && !I_POR && !I_BROWNOUT_RESET_EVENT && !I_MASTER_CLEAR_PIN && !I_WDT_TIMEOUT)
      |=> !O_LOAD)
      else $error("irq while awake caused a load");
endmodule : rsl_loader

// file: testbench/rsl_loader_bench.sv
// Testbench of the reset state loader
module rsl_loader_bench
   import rsl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic por = 1'b0, brownout = 1'b0, pin = 1'b0, wdt = 1'b0, irq = 1'b0, slp = 1'b0;
   logic opt_we = 1'b0, gen_we = 1'b0;
   logic [12:0] pc = 13'h0000;
   logic [7:0] wf1 = 8'h00, wf2 = 8'h00, wic = 8'h00, opt_wr = 8'h00, gen_wr = 8'h00;
   logic [12:0] o_pc;
   logic [7:0] o_st, o_op, o_ic, o_p1, o_p2, o_gn;
   logic [1:0] o_pw;
   logic [2:0] o_cs;
   logic o_ld;
   int err_count = 0;
   int tests_run = 0;
   always #5 mclk = ~mclk;
   rsl_loader DUT (.I_MCLK(mclk), .I_NRST(nrst), .I_POR(por), .I_BROWNOUT_RESET_EVENT(brownout),
      .I_MASTER_CLEAR_PIN(pin), .I_WDT_TIMEOUT(wdt), .I_IRQ_WAKE(irq), .I_SLEEPING(slp),
      .I_PC(pc), .I_WAKE_FLAGS1(wf1), .I_WAKE_FLAGS2(wf2), .I_WAKE_IRQCTL(wic),
      .I_OPTION_WR(opt_wr), .I_OPTION_WE(opt_we), .I_GEN_WR(gen_wr), .I_GEN_WE(gen_we),
      .O_PC(o_pc), .O_STATUS(o_st), .O_OPTION(o_op), .O_IRQ_CONTROL_REG(o_ic),
      .O_PERIPH_FLAG_REG_ONE(o_p1), .O_PERIPH_FLAG_REG_TWO(o_p2), .O_POWER_STATUS_REG(o_pw),
      .O_GEN_REG(o_gn), .O_CAUSE(o_cs), .O_LOAD(o_ld));
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   // Event bits {por, brownout, pin, wdt, irq}; outputs are sampled just after the load edge
   task automatic fire(input logic [4:0] ev);
      @(posedge mclk);
      {por, brownout, pin, wdt, irq} <= ev;
      @(posedge mclk);
      {por, brownout, pin, wdt, irq} <= 5'h00;
      #1;
   endtask : fire
   task automatic wr(input logic [7:0] o, input logic [7:0] g);
      @(posedge mclk);
      {opt_we, gen_we, opt_wr, gen_wr} <= {2'b11, o, g};
      @(posedge mclk);
      {opt_we, gen_we} <= 2'b00;
      #1;
   endtask : wr
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_pin_reset();
      wr(8'h12, 8'h5a);
      check("option wr", 16'h0012, o_op);
      fire(5'b00100);
      check("cause", RSL_PIN, o_cs);
      check("load", 16'h0001, o_ld);
      check("pc", RSL_PC_RESET, o_pc);
      check("option", RSL_OPTION_RESET, o_op);
      check("status", 16'h0003, o_st[7:3]);
      check("gen", 16'h005a, o_gn);
      @(posedge mclk);
      #1;
      check("load end", 16'h0000, o_ld);
   endtask : t_pin_reset
   task automatic t_wdt_reset();
      fire(5'b00010);
      check("cause", RSL_WDT, o_cs);
      check("status", 16'h0001, o_st[7:3]);
   endtask : t_wdt_reset
   task automatic t_wake_wdt();
      wr(8'h34, 8'h66);
      @(posedge mclk);
      {slp, pc} <= {1'b1, 13'h0123};
      fire(5'b00011);
      check("cause", RSL_WAKE_WDT, o_cs);
      check("pc", 16'h0124, o_pc);
      check("status", 16'h0000, o_st[4:3]);
      check("option", 16'h0034, o_op);
      check("gen", 16'h0066, o_gn);
   endtask : t_wake_wdt
   task automatic t_wake_irq();
      @(posedge mclk);
      {pc, wf1, wf2, wic} <= {13'h0200, 8'h7f, 8'hff, 8'h80};
      fire(5'b00001);
      check("pc", 16'h0201, o_pc);
      check("status", 16'h0002, o_st[4:3]);
      check("pfr1", RSL_PFR1_IMPL, o_p1);
      check("pfr2", RSL_PFR2_IMPL, o_p2);
      check("irqctl", 16'h0080, o_ic);
      @(posedge mclk);
      {wf1, wf2, wic} <= 24'h0;
      fire(5'b00001);
      check("cause", RSL_WAKE_IRQ, o_cs);
      check("pc vec", RSL_PC_VECTOR, o_pc);
      check("irqctl", 16'h0081, o_ic);
      fire(5'b00100);
      check("cause", RSL_PIN_SLEEP, o_cs);
      check("status", 16'h0002, o_st[4:3]);
      check("irqctl", RSL_IRQCTL_RESET, o_ic);
      check("pfr1", 16'h0000, o_p1);
   endtask : t_wake_irq
   task automatic t_priority();
      fire(5'b00011);
      check("wdt over irq", RSL_WAKE_WDT, o_cs);
      fire(5'b00110);
      check("pin over wdt", RSL_PIN_SLEEP, o_cs);
      @(posedge mclk);
      slp <= 1'b0;
      fire(5'b00001);
      check("irq awake", 16'h0000, o_ld);
      fire(5'b10100);
      check("por first", RSL_POR, o_cs);
      check("status", RSL_STATUS_COLD, o_st);
      check("pwr", 16'h0000, o_pw[1]);
      check("gen por", 16'h0000, o_gn);
      fire(5'b01010);
      check("brownout first", RSL_BROWNOUT, o_cs);
      check("pwr", 16'h0000, o_pw[0]);
      check("status", 16'h0003, o_st[4:3]);
   endtask : t_priority
   task automatic t_mid_reset();
      fire(5'b00010);
      wr(8'h55, 8'h77);
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      #1;
      check("status mid rst", RSL_STATUS_COLD, o_st);
      check("option mid rst", RSL_OPTION_RESET, o_op);
      check("gen mid rst", 16'h0000, o_gn);
      check("cause mid rst", RSL_NONE, o_cs);
      check("load mid rst", 16'h0000, o_ld);
      fire(5'b00100);
      check("pin after rst", RSL_PIN, o_cs);
   endtask : t_mid_reset
   initial begin
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      #1;
      check("pc rst", RSL_PC_RESET, o_pc);
      check("status rst", RSL_STATUS_COLD, o_st);
      check("option rst", RSL_OPTION_RESET, o_op);
      check("load rst", 16'h0000, o_ld);
      t_pin_reset();
      t_wdt_reset();
      t_wake_wdt();
      t_wake_irq();
      t_priority();
      t_mid_reset();
      conclude();
   end
endmodule : rsl_loader_bench
